/* pkg/spl_pkg.sv */
package spl_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CAPTURE = 8'h08;

	// control word layout
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PORT_LSB = 2;
	localparam int CTRL_PDO_LSB = 11;
	localparam int CTRL_CASCADE_DATA_OUT_LSB = 13;
	localparam int CTRL_W = 15;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

	// per-port config: bit 0 connect, bits 2:1 data source
	localparam int NPORT = 3;
	localparam int PCFG_W = 3;
	localparam int PCFG_CONN = 0;
	localparam int PCFG_SRC = 1;
	localparam logic [1:0] SRC_PDI = 2'h0;
	localparam logic [1:0] SRC_PREV = 2'h1;
	localparam logic [1:0] SRC_CDI = 2'h2;

	// status word layout
	localparam int STAT_TAP_LSB = 0;
	localparam int STAT_OK_BIT = 4;
	localparam int STAT_ACT_LSB = 5;
	localparam int STAT_ST_LSB = 8;

	// synchroniser lanes and idle level of undriven pins
	// test clock lane (msb) idles low so reset makes no false edge
	localparam int NSYNC = 18;
	localparam logic [NSYNC-1:0] SYNC_IDLE = 18'h1FFFF;
	localparam logic [31:0] CAPTURE_RESET = 32'h00000000;

	// software mode field
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h1;
	localparam logic [1:0] MODE_MCAST = 2'h2;
	localparam logic [1:0] MODE_RESET = 2'h3;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ON = 3'h1,
		ST_MULTICAST = 3'h2,
		ST_RESET = 3'h3,
		ST_TEST_RESET = 3'h4,
		ST_PIN_OVERRIDE = 3'h5,
		ST_OVERRIDE_WITH_RESET = 3'h6
	} spl_status_e;

	typedef enum logic [3:0] {
		TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3, TAP_SHIFT_DR = 4'h4, TAP_EX1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
		TAP_EX1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EX2_IR = 4'hE,
		TAP_UPD_IR = 4'hF
	} spl_tap_e;

endpackage

/* logic/spl_tap_follow.sv */
`timescale 1ns/1ps
`default_nettype none
module spl_tap_follow (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clear,
	input wire logic tckRise,
	input wire logic tms,
	output spl_pkg::spl_tap_e tapState,
	output logic tapStable
);
	import spl_pkg::*;

	spl_tap_e next_tapState;

	// standard tap graph, advanced only on test clock rises
	always_comb begin
		case (tapState)
			TAP_TLR: next_tapState = tms ? TAP_TLR : TAP_RTI;
			TAP_RTI: next_tapState = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: next_tapState = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tapState = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: next_tapState = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_EX1_DR: next_tapState = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: next_tapState = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
			TAP_EX2_DR: next_tapState = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: next_tapState = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: next_tapState = tms ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: next_tapState = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: next_tapState = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_EX1_IR: next_tapState = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: next_tapState = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
			TAP_EX2_IR: next_tapState = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: next_tapState = tms ? TAP_SEL_DR : TAP_RTI;
			default: next_tapState = TAP_TLR;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tapState <= TAP_TLR;
		end else if (ce) begin
			if (clear) begin
				tapState <= TAP_TLR;
			end else if (tckRise) begin
				tapState <= next_tapState;
			end
		end
	end

	always_comb begin
		case (tapState)
			TAP_TLR, TAP_RTI, TAP_PAUSE_DR, TAP_PAUSE_IR: tapStable = 1'b1;
			default: tapStable = 1'b0;
		endcase
	end

endmodule // spl_tap_follow
`default_nettype wire

/* logic/spl_link_top.sv */
// Overview of operation
// - Track the tap controller state by sampling mode select on test clocks.
// - Protocols accepted only in reset, idle and pause states, never shifting.
// - Forward primary mode select to selected secondary ports when connected.
// - Always forward primary test reset to all secondary resets.
// - Low test reset gives test-reset status, or bypass-reset if override low.
// - Low test reset returns state to power-up without clock edge; pins still set control if override low.
// - Protocols are answered only while primary test reset is high.
// - Secondary test clocks always copy the primary test clock.
// - Secondary data inputs route to a secondary or primary data output.
// - Secondary data outputs take secondary, primary or cascade input.
// - Off, reset and test-reset put secondary data outputs high impedance.
// - Secondary data outputs change only on test clock falls.
// - Mode select of an off port holds its last valid value.
// - Reset-type statuses force secondary mode selects high.
// - Cascade output takes a secondary input or the cascade input.
// - Cascade output changes only on test clock falls.
// - Secondary pass-through inputs may route to primary pass-through output.
// - Primary pass-through input drives every connected port's output.
// - Pass-through outputs of disconnected ports are high impedance.
// - Unconnected inputs read high; the test clock lane idles low.
// - With master override low, protocols ignored; pins configure ports.
// - Connect flags low for active statuses, high otherwise.
// - During protocols, primary data bits are captured on test clock rises.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spl_link_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic primary_test_clock,
	input wire logic primary_mode_select,
	input wire logic primary_test_reset_n,
	input wire logic primary_data_in,
	output logic primary_data_out,
	output logic primary_data_out_oe,
	input wire logic cascade_data_in,
	output logic cascade_data_out,
	input wire logic override_master_n,
	input wire logic [4:0] override_config_pins_n,
	output logic [2:0] secondary_test_clocks,
	output logic [2:0] secondary_test_resets_n,
	output logic [2:0] secondary_mode_selects,
	input wire logic [2:0] secondary_data_inputs,
	output logic [2:0] secondary_data_outputs,
	output logic [2:0] secondary_data_outputs_oe,
	input wire logic [2:0] secondary_passthru_inputs,
	output logic [2:0] secondary_passthru_outputs,
	output logic [2:0] secondary_passthru_outputs_oe,
	input wire logic primary_passthru_input,
	output logic primary_passthru_output,
	output logic [2:0] link_active_flags_n
);
	import spl_pkg::*;

	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] syncA;
	logic [NSYNC-1:0] syncB;
	logic tckS, tmsS, rstnS, pdiS, cdiS, pxS, ovmS;
	logic [2:0] sdiS;
	logic [2:0] sxS;
	logic [4:0] ovcS;
	logic tckPrev;
	logic tckRise;
	logic tckFall;
	spl_tap_e tapState;
	logic tapStable;
	logic protoOk;
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] pinCtrl;
	spl_status_e status;
	logic [1:0] mode;
	logic [NPORT*PCFG_W-1:0] portCfg;
	logic [1:0] pdoSel;
	logic [1:0] ctdoSel;
	logic [2:0] conn;
	logic [2:0] active;
	logic [2:0] sdoNext;
	logic connStatus;
	logic resetType;
	logic msForward;
	logic pdoDrive;
	logic pyNext;
	logic [31:0] capture;
	logic setup;
	logic commit;
	logic errNext;
	logic [31:0] rdNext;

	// pick a secondary input by 1-based code, or the fallback on code 0
	function automatic logic pickIn(input logic [1:0] sel,
			input logic base, input logic [2:0] sdi);
		pickIn = (sel == 2'h0) ? base : sdi[sel - 2'h1];
	endfunction

	// pin wiring: connected ports chained 0..2 if pin 4 high, last one to primary out
	function automatic logic [CTRL_W-1:0] pinDecode(input logic [4:0] p);
		logic [CTRL_W-1:0] c;
		logic [1:0] last;
		c = CTRL_RESET;
		last = 2'h0;
		for (int i = 0; i < NPORT; i++) begin
			if (!p[i]) begin
				c[CTRL_PORT_LSB + i*PCFG_W + PCFG_CONN] = 1'b1;
				if (p[4] && last != 2'h0) begin
					c[CTRL_PORT_LSB + i*PCFG_W + PCFG_SRC +: 2] = SRC_PREV;
				end
				last = 2'(i + 1);
			end
		end
		c[CTRL_PDO_LSB +: 2] = last;
		c[CTRL_CASCADE_DATA_OUT_LSB +: 2] = p[3] ? 2'h0 : last;
		pinDecode = c;
	endfunction

	// pin lanes; idle level after reset is high, test clock low
	assign pinRaw = {primary_test_clock, primary_mode_select,
		primary_test_reset_n, primary_data_in, cascade_data_in,
		primary_passthru_input, override_master_n,
		secondary_data_inputs, secondary_passthru_inputs,
		override_config_pins_n};

	// two-flop synchronisers for every pin
	// undriven reads high, test clock low
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : gSync
			always_ff @(posedge mclk) begin
				if (rst) begin
					syncA[g] <= SYNC_IDLE[g];
					syncB[g] <= SYNC_IDLE[g];
				end else if (ce) begin
					syncA[g] <= pinRaw[g];
					syncB[g] <= syncA[g];
				end
			end
		end
	endgenerate

	assign {tckS, tmsS, rstnS, pdiS, cdiS, pxS, ovmS, sdiS, sxS, ovcS} = syncB;

	// test clock edge finder
	always_ff @(posedge mclk) begin
		if (rst) begin
			tckPrev <= 1'b0;
		end else if (ce) begin
			tckPrev <= tckS;
		end
	end
	assign tckRise = tckS & ~tckPrev;
	assign tckFall = ~tckS & tckPrev;

	spl_tap_follow spl_tap_follow_inst (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.clear(~rstnS),
		.tckRise(tckRise),
		.tms(tmsS),
		.tapState(tapState),
		.tapStable(tapStable)
	);

	assign protoOk = rstnS & ovmS & tapStable;

	// overall status
	// reset statuses
	always_comb begin
		if (!rstnS) begin
			status = ovmS ? ST_TEST_RESET : ST_OVERRIDE_WITH_RESET;
		end else if (!ovmS) begin
			status = ST_PIN_OVERRIDE;
		end else begin
			case (mode)
				MODE_ON: status = ST_ON;
				MODE_MCAST: status = ST_MULTICAST;
				MODE_RESET: status = ST_RESET;
				default: status = ST_OFF;
			endcase
		end
	end

	// status classes used by the muxes
	always_comb begin
		connStatus = 1'b0;
		resetType = 1'b0;
		msForward = 1'b0;
		pdoDrive = 1'b0;
		case (status)
			ST_ON, ST_PIN_OVERRIDE: begin
				connStatus = 1'b1;
				msForward = 1'b1;
				pdoDrive = 1'b1;
			end
			ST_MULTICAST: begin
				connStatus = 1'b1;
				msForward = 1'b1;
			end
			ST_OVERRIDE_WITH_RESET: begin
				connStatus = 1'b1;
				resetType = 1'b1;
				pdoDrive = 1'b1;
			end
			ST_RESET, ST_TEST_RESET: resetType = 1'b1;
			default: connStatus = 1'b0;
		endcase
	end

	// apb handshake: decision at setup, answer in first access cycle
	assign setup = psel & ~penable & ~pready;
	assign commit = psel & penable & pready & pwrite & ~pslverr;
	assign pinCtrl = pinDecode(ovcS);

	always_comb begin
		errNext = 1'b0;
		rdNext = 32'h00000000;
		case (paddr)
			REG_CTRL: begin
				errNext = pwrite & ~protoOk;
				rdNext[CTRL_W-1:0] = ctrl;
			end
			REG_STATUS: begin
				errNext = pwrite;
				rdNext[STAT_TAP_LSB +: 4] = tapState;
				rdNext[STAT_OK_BIT] = protoOk;
				rdNext[STAT_ACT_LSB +: 3] = active;
				rdNext[STAT_ST_LSB +: 3] = status;
			end
			REG_CAPTURE: begin
				errNext = pwrite;
				rdNext = capture;
			end
			default: errNext = 1'b1;
		endcase
	end

	// bus answer registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (ce) begin
			pready <= setup;
			if (setup) begin
				pslverr <= errNext;
				prdata <= pwrite ? 32'h00000000 : rdNext;
			end else if (pready) begin
				pslverr <= 1'b0;
				prdata <= 32'h00000000;
			end
		end
	end

	// pins win while master override low
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
		end else if (ce) begin
			// pins keep ports wired through bypass-reset as well
			if (!ovmS) begin
				ctrl <= pinCtrl;
			end else if (!rstnS) begin
				ctrl <= CTRL_RESET;
			end else if (commit && paddr == REG_CTRL) begin
				ctrl <= pwdata[CTRL_W-1:0];
			end
		end
	end

	assign mode = ctrl[CTRL_MODE_LSB +: 2];
	assign portCfg = ctrl[CTRL_PORT_LSB +: NPORT*PCFG_W];
	assign pdoSel = ctrl[CTRL_PDO_LSB +: 2];
	assign ctdoSel = ctrl[CTRL_CASCADE_DATA_OUT_LSB +: 2];

	generate
		for (g = 0; g < NPORT; g++) begin : gPort
			logic [1:0] src;
			logic prevIn;
			assign src = portCfg[g*PCFG_W + PCFG_SRC +: 2];
			assign conn[g] = portCfg[g*PCFG_W + PCFG_CONN];
			assign active[g] = conn[g] & connStatus;
			if (g == 0) begin : gFirst
				assign prevIn = cdiS;
			end else begin : gRest
				assign prevIn = sdiS[g-1];
			end
			assign sdoNext[g] = (src == SRC_PREV) ? prevIn :
				(src == SRC_CDI) ? cdiS : pdiS;
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			secondary_test_clocks <= 3'b000;
			secondary_test_resets_n <= 3'b111;
		end else if (ce) begin
			secondary_test_clocks <= {NPORT{tckS}};
			secondary_test_resets_n <= {NPORT{rstnS}};
		end
	end

	// secondary mode selects
	always_ff @(posedge mclk) begin
		if (rst) begin
			secondary_mode_selects <= 3'b111;
		end else if (ce) begin
			for (int i = 0; i < NPORT; i++) begin
				if (resetType) begin
					secondary_mode_selects[i] <= 1'b1;
				end else if (msForward && conn[i]) begin
					secondary_mode_selects[i] <= tmsS;
				end
			end
		end
	end

	// data paths change on test clock falls; drives drop at once in reset and test-reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			secondary_data_outputs <= 3'b111;
			secondary_data_outputs_oe <= 3'b000;
			primary_data_out <= 1'b1;
			primary_data_out_oe <= 1'b0;
			cascade_data_out <= 1'b1;
			link_active_flags_n <= 3'b111;
		end else if (ce) begin
			if (resetType && !connStatus) begin
				secondary_data_outputs_oe <= 3'b000;
				primary_data_out_oe <= 1'b0;
				link_active_flags_n <= 3'b111;
			end else if (tckFall) begin
				secondary_data_outputs <= sdoNext;
				secondary_data_outputs_oe <= active;
				primary_data_out <= pickIn(pdoSel, pdiS, sdiS);
				primary_data_out_oe <= pdoDrive;
				link_active_flags_n <= ~active;
			end
			if (tckFall) begin
				cascade_data_out <= pickIn(ctdoSel, cdiS, sdiS);
			end
		end
	end

	// lowest active port feeds primary pass-through
	always_comb begin
		pyNext = 1'b1;
		for (int i = NPORT - 1; i >= 0; i--) begin
			if (active[i]) begin
				pyNext = sxS[i];
			end
		end
	end

	// pass-through pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			primary_passthru_output <= 1'b1;
			secondary_passthru_outputs <= 3'b111;
			secondary_passthru_outputs_oe <= 3'b000;
		end else if (ce) begin
			primary_passthru_output <= pyNext;
			secondary_passthru_outputs <= {NPORT{pxS}};
			secondary_passthru_outputs_oe <= active;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			capture <= CAPTURE_RESET;
		end else if (ce) begin
			if (!rstnS) begin
				capture <= CAPTURE_RESET;
			end else if (tckRise && protoOk) begin
				capture <= {capture[30:0], pdiS};
			end
		end
	end

	a_tck_copy: assert property (@(posedge mclk) disable iff (rst || !ce)
		$rose(tckS) |=> secondary_test_clocks == 3'b111)
		else $error("secondary clocks miss rise");
	a_reset_fwd: assert property (@(posedge mclk) disable iff (rst || !ce)
		!rstnS |=> secondary_test_resets_n == 3'b000)
		else $error("test reset not forwarded");
	a_ms_forced: assert property (@(posedge mclk) disable iff (rst || !ce)
		resetType |=> secondary_mode_selects == 3'b111)
		else $error("mode selects not forced high");
	a_ms_hold: assert property (@(posedge mclk) disable iff (rst || !ce)
		status == ST_OFF |=> $stable(secondary_mode_selects))
		else $error("off port mode select moved");
	a_sdo_fall: assert property (@(posedge mclk) disable iff (rst || !ce)
		!tckFall |=> $stable(secondary_data_outputs))
		else $error("data out changed off a fall");
	a_cascade_data_out_fall: assert property (@(posedge mclk) disable iff (rst || !ce)
		!tckFall |=> $stable(cascade_data_out))
		else $error("cascade out changed off a fall");
	a_proto_gate: assert property (@(posedge mclk) disable iff (rst || !ce)
		commit && paddr == REG_CTRL |-> $past(protoOk))
		else $error("config taken outside stable state");
	a_sy_release: assert property (@(posedge mclk) disable iff (rst || !ce)
		!active[0] |=> !secondary_passthru_outputs_oe[0])
		else $error("pass-through driven while disconnected");
	a_ovr_reset: assert property (@(posedge mclk) disable iff (rst || !ce)
		!rstnS && !ovmS |-> status == ST_OVERRIDE_WITH_RESET)
		else $error("bypass-reset status missing");
	a_data_hiz: assert property (@(posedge mclk) disable iff (rst || !ce)
		status == ST_TEST_RESET ##1 status == ST_TEST_RESET
		|-> secondary_data_outputs_oe == 3'b000)
		else $error("data out driven in test reset");

endmodule // spl_link_top
`default_nettype wire

/* dv/spl_jtag_master.sv */
`timescale 1ns/1ps
`default_nettype none
module spl_jtag_master (
	input wire logic mclk,
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	output var logic trstN
);
	// lines rest at their pull-up level, test clock low
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trstN = 1'b1;
	end
	// callers keep to stable tap states between frames
	// 10 cycles high and 10 low give the 160 ns test clock period
	task automatic rise(input logic m, input logic d);
		@(posedge mclk);
		tms <= m;
		tdi <= d;
		repeat (5) @(posedge mclk);
		tck <= 1'b1;
		repeat (9) @(posedge mclk);
	endtask
	// gated clock: parked low until the next bit
	task automatic fall();
		@(posedge mclk);
		tck <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic pulse(input logic m, input logic d);
		rise(m, d);
		fall();
	endtask
	// change lines with the clock standing still
	task automatic hold(input logic m, input logic d);
		@(posedge mclk);
		tms <= m;
		tdi <= d;
	endtask
	task automatic setReset(input logic v);
		@(posedge mclk);
		trstN <= v;
	endtask
endmodule // spl_jtag_master
`default_nettype wire

/* dv/spl_link_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spl_link_top_test;
	import spl_pkg::*;
	typedef struct {logic [32:0] exp; logic [32:0] mask; int grp;} spl_note_s;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, act;
	logic [7:0] paddr;
	logic [7:0] capExp;
	logic [31:0] pwdata, prdata;
	logic tck, tms, tdi, trstN, priOut, priOe, cascIn, cascOut, ovrN;
	logic priPassIn, priPassOut;
	logic [4:0] ovrCfgN;
	logic [2:0] secClk, secRstN, secMs, secIn, secOut, secOe;
	logic [2:0] secPassIn, secPassOut, secPassOe, flagsN;
	logic [15:0] lfsr = 16'hEC93;
	spl_note_s noteQ[$];
	int nFail = 0;
	int nChecks = 0;

	spl_link_top spl_link_top_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_test_clock(tck), .primary_mode_select(tms),
		.primary_test_reset_n(trstN), .primary_data_in(tdi),
		.primary_data_out(priOut), .primary_data_out_oe(priOe),
		.cascade_data_in(cascIn), .cascade_data_out(cascOut),
		.override_master_n(ovrN), .override_config_pins_n(ovrCfgN),
		.secondary_test_clocks(secClk), .secondary_test_resets_n(secRstN),
		.secondary_mode_selects(secMs), .secondary_data_inputs(secIn),
		.secondary_data_outputs(secOut), .secondary_data_outputs_oe(secOe),
		.secondary_passthru_inputs(secPassIn),
		.secondary_passthru_outputs(secPassOut),
		.secondary_passthru_outputs_oe(secPassOe),
		.primary_passthru_input(priPassIn),
		.primary_passthru_output(priPassOut), .link_active_flags_n(flagsN));
	spl_jtag_master spl_jtag_master_inst (.mclk(mclk), .tck(tck), .tms(tms),
		.tdi(tdi), .trstN(trstN));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	function automatic logic [15:0] step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// observed pin groups, picked by note
	function automatic logic [32:0] grpVal(input int g);
		case (g)
			0: return 33'(flagsN);
			1: return 33'(secMs);
			2: return 33'(secRstN);
			3: return 33'(secOe);
			4: return 33'(secOut[0]);
			5: return 33'(secPassOe);
			6: return 33'(secPassOut[0]);
			7: return 33'({priOe, cascOut, priPassOut, priOut});
			default: return 33'(secClk);
		endcase
	endfunction

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [32:0] got);
		spl_note_s n;
		n = noteQ.pop_front();
		nChecks++;
		if ((got & n.mask) !== (n.exp & n.mask)) begin
			nFail++;
			$display("BAD %0t exp %h got %h", $time, n.exp & n.mask, got & n.mask);
		end
	endtask

	// apb answers judged at their sampling edge
	always @(posedge mclk) begin
		if ((psel & penable & pready) === 1'b1) cmp({pslverr, prdata});
	end
	// pin notes judged mid-cycle, well after the edge
	always @(negedge mclk) begin
		while (noteQ.size() > 0 && noteQ[0].grp >= 0) cmp(grpVal(noteQ[0].grp));
	end

	task automatic pin(input int g, input logic [3:0] v);
		noteQ.push_back('{33'(v), {33{1'b1}}, g});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e, input logic [31:0] m);
		noteQ.push_back('{e, {1'b1, m}, -1});
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no fixed latency assumed; the watchdog ends a hung wait
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic r);
		apb(1'b1, a, d, {r, 32'h0}, '1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, e}, m);
	endtask

	initial begin
		repeat (30000) @(posedge mclk);
		nFail++;
		endOfTest();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		// first in the cascade: input left at its pull-up level
		cascIn = 1'b1;
		ovrN = 1'b1;
		ovrCfgN = 5'h1F;
		secIn = 3'h7;
		secPassIn = 3'h7;
		priPassIn = 1'b1;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		settle(2);
		pin(0, 4'h7);
		pin(1, 4'h7);
		pin(2, 4'h7);
		pin(3, 4'h0);
		pin(5, 4'h0);
		rd(REG_STATUS, 32'h10, '1);
		apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0}, '1);
		wr(REG_STATUS, 32'h1, 1'b1);
		// idle, then random bits into the capture register
		spl_jtag_master_inst.pulse(1'b0, 1'b1);
		capExp = 8'h00;
		for (int i = 0; i < 8; i++) begin
			lfsr = step(lfsr);
			capExp = {capExp[6:0], lfsr[0]};
			spl_jtag_master_inst.pulse(1'b0, lfsr[0]);
		end
		rd(REG_CAPTURE, 32'(capExp), 32'hFF);
		// every mode with port zero connected, tms held low
		for (int m = 0; m < 4; m++) begin
			act = (m == 1 || m == 2);
			wr(REG_CTRL, 32'h4 | 32'(m), 1'b0);
			spl_jtag_master_inst.pulse(1'b0, 1'b1);
			settle(4);
			rd(REG_STATUS, 32'h11 | (32'(act) << 5) | (32'(m) << 8), '1);
			pin(0, act ? 4'h6 : 4'h7);
			pin(3, {3'h0, act});
			pin(1, act ? 4'h6 : 4'h7);
		end
		// port zero on, random far-side levels
		lfsr = step(lfsr);
		@(posedge mclk);
		secIn <= lfsr[2:0];
		secPassIn <= lfsr[5:3];
		priPassIn <= lfsr[6];
		cascIn <= lfsr[7];
		wr(REG_CTRL, 32'h2805, 1'b0);
		rd(REG_CTRL, 32'h2805, '1);
		spl_jtag_master_inst.rise(1'b0, lfsr[8]);
		settle(4);
		pin(8, 4'h7);
		spl_jtag_master_inst.fall();
		settle(4);
		pin(8, 4'h0);
		pin(4, {3'h0, lfsr[8]});
		pin(7, {1'b1, lfsr[0], lfsr[3], lfsr[0]});
		pin(6, {3'h0, lfsr[6]});
		pin(5, 4'h1);
		pin(1, 4'h6);
		// data in moves with the clock parked: output must not follow
		spl_jtag_master_inst.hold(1'b0, ~lfsr[8]);
		settle(6);
		pin(4, {3'h0, lfsr[8]});
		// port zero fed from the cascade input, primary data differs
		wr(REG_CTRL, 32'h0815, 1'b0);
		spl_jtag_master_inst.pulse(1'b0, ~lfsr[7]);
		settle(4);
		pin(7, {1'b1, lfsr[7], lfsr[3], lfsr[0]});
		pin(4, {3'h0, lfsr[7]});
		// switched off: mode select keeps its last level
		wr(REG_CTRL, 32'h2804, 1'b0);
		spl_jtag_master_inst.hold(1'b1, 1'b1);
		settle(6);
		pin(1, 4'h6);
		// into Shift-DR, where control writes are refused
		for (int i = 0; i < 3; i++) spl_jtag_master_inst.pulse(i == 0, 1'b1);
		settle(4);
		rd(REG_STATUS, 32'h4, '1);
		wr(REG_CTRL, 32'h5, 1'b1);
		repeat (5) spl_jtag_master_inst.pulse(1'b1, 1'b1);
		settle(4);
		rd(REG_STATUS, 32'h10, '1);
		// test reset low, then with the override pin low too
		spl_jtag_master_inst.setReset(1'b0);
		settle(5);
		pin(2, 4'h0);
		pin(1, 4'h7);
		pin(3, 4'h0);
		pin(0, 4'h7);
		rd(REG_STATUS, 32'h400, '1);
		rd(REG_CTRL, 32'h0, '1);
		wr(REG_CTRL, 32'h5, 1'b1);
		@(posedge mclk);
		ovrN <= 1'b0;
		settle(5);
		rd(REG_STATUS, 32'h600, '1);
		// pins wire ports 0 and 1 even while test reset is low
		@(posedge mclk);
		ovrCfgN <= 5'h1C;
		spl_jtag_master_inst.pulse(1'b1, 1'b1);
		settle(4);
		rd(REG_STATUS, 32'h660, '1);
		pin(0, 4'h4);
		pin(3, 4'h3);
		spl_jtag_master_inst.setReset(1'b1);
		spl_jtag_master_inst.pulse(1'b1, 1'b1);
		settle(4);
		rd(REG_STATUS, 32'h560, '1);
		pin(0, 4'h4);
		pin(3, 4'h3);
		pin(2, 4'h7);
		wr(REG_CTRL, 32'h5, 1'b1);
		settle(2);
		endOfTest();
	end
endmodule // spl_link_top_test
`default_nettype wire
